//--- include/fllot_pkg.sv
// package: constants for the frequency lock loop oscillator tracking block
package fllot_pkg;
  localparam int TAP_W = 5;
  localparam int MOD_W = 5;
  localparam int CNT_W = 16;
  localparam int DW = 32;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TARGET = 8'h04;
  localparam logic [7:0] OFS_SETTING = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_LASTCNT = 8'h10;
  // control fields
  localparam int CTRL_LEVEL_LSB = 0;
  localparam int CTRL_LEVEL_W = 3;
  localparam int CTRL_GEN_OFF = 3;
  localparam int CTRL_OSC_AUX = 4;
  localparam int CTRL_OSC_SUB = 5;
  localparam int CTRL_IN_HANDLER = 6;
  localparam int CTRL_BYPASS1 = 7;
  localparam int CTRL_XT1_HF = 8;
  localparam int CTRL_BYPASS2 = 9;
  localparam int CTRL_TIMER_ON = 10;
  localparam int CTRL_W = 11;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [CNT_W-1:0] TARGET_RST = 16'h0020;
  localparam logic [TAP_W+MOD_W-1:0] SETTING_RST = 10'h200;
  // sleep levels
  localparam logic [2:0] LVL_ACTIVE = 3'h7;
  localparam logic [2:0] LVL_ZERO = 3'h0;
  localparam logic [2:0] LVL_ONE = 3'h1;
  localparam logic [2:0] LVL_TWO = 3'h2;
  localparam logic [2:0] LVL_FOUR = 3'h4;
  // reference periods per loop iteration
  localparam int CAPTURE_PERIODS = 2;
  localparam int APPLY_PERIODS = 1;
  localparam int MIN_ENABLE_PERIODS = CAPTURE_PERIODS + APPLY_PERIODS;
  typedef enum logic [3:0] {
    FLLOT_IDLE = 4'h1,
    FLLOT_ARM = 4'h2,
    FLLOT_COUNT = 4'h4,
    FLLOT_APPLY = 4'h8
  } fllot_state_e;
endpackage

//--- logic/fllot_step.sv
// combined tap and modulation stepper with saturation
`timescale 1ns/1ps
module fllot_step #(
  parameter int TAP_W = fllot_pkg::TAP_W,
  parameter int MOD_W = fllot_pkg::MOD_W
) (
  input wire logic [TAP_W-1:0] tap,
  input wire logic [MOD_W-1:0] modv,
  input wire logic up,
  input wire logic down,
  output logic [TAP_W-1:0] tap_nxt,
  output logic [MOD_W-1:0] mod_nxt
);
  logic [TAP_W+MOD_W-1:0] comb;
  logic mod_full;
  logic mod_zero;
  logic at_top;
  logic at_bot;

  assign comb = {tap, modv};
  assign mod_full = &modv;
  assign mod_zero = ~|modv;
  assign at_top = &comb;
  assign at_bot = ~|comb;

  always_comb begin
    tap_nxt = tap;
    mod_nxt = modv;
    if (up && !at_top) begin
      // rollover: modulation wraps to zero and tap rises
      if (mod_full) begin
        tap_nxt = tap + {{(TAP_W-1){1'b0}}, 1'b1};
        mod_nxt = '0;
      end else begin
        mod_nxt = modv + {{(MOD_W-1){1'b0}}, 1'b1};
      end
    end else if (down && !at_bot) begin
      if (mod_zero) begin
        tap_nxt = tap - {{(TAP_W-1){1'b0}}, 1'b1};
        mod_nxt = '1;
      end else begin
        mod_nxt = modv - {{(MOD_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

//--- logic/fllot_top.sv
// frequency lock loop tracking a tunable oscillator against a reference
//
// Function
// - measure oscillator over window between two successive reference rising edges
// - iteration uses two periods to capture, one more to apply adjustment
// - loop off in level 0 without aux/sub-main use, levels 2-4 with generator off
// - handler entry from level 0/2 or return to active re-enables loop immediately
// - short enable intervals must not corrupt settings; software keeps three periods
// - while enabled, update both tap-select and modulation fields automatically
// - modulation dithers between selected tap and tap plus one
// - at tap boundary the modulation rolls over into the next tap correctly
// - level 4 low-current mode only when no bypass input remains on
// - writing zero to the first oscillator bypass bit turns bypass off
// - level 1 keeps loop off in handlers when oscillator feeds no clock
// - level 0 with oscillator-derived timer clock keeps loop and oscillator active
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module fllot_top #(
  parameter int TAP_W = fllot_pkg::TAP_W,
  parameter int MOD_W = fllot_pkg::MOD_W,
  parameter int CNT_W = fllot_pkg::CNT_W
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic ref_clk_in,
  input wire logic osc_clk_in,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [TAP_W-1:0] tap_select_field,
  output logic [MOD_W-1:0] modulation_field,
  output logic tap_dither_sel,
  output logic frequency_lock_loop_on,
  output logic tunable_oscillator_on,
  output logic power_manager_low_current
);
  localparam int SW = TAP_W + MOD_W;

  logic [fllot_pkg::CTRL_W-1:0] ctrl_r;
  logic [CNT_W-1:0] target_r;
  logic [TAP_W-1:0] tap_r;
  logic [MOD_W-1:0] mod_r;
  logic [CNT_W-1:0] osc_cnt_r;
  logic [CNT_W-1:0] last_cnt_r;
  logic [1:0] ref_hist_r;
  logic [1:0] osc_hist_r;
  logic [MOD_W-1:0] dith_acc_r;
  logic dith_r;
  logic rd_ack_r;
  logic [31:0] rdata_r;
  logic low_cur_r;
  logic loop_en_r;
  fllot_pkg::fllot_state_e state_r;
  fllot_pkg::fllot_state_e state_nxt;

  logic [2:0] level;
  logic gen_off;
  logic osc_used;
  logic in_handler;
  logic timer_on;
  logic bypass_on;
  logic loop_en;
  logic ref_rise;
  logic osc_rise;
  logic wr_hit;
  logic sw_setting_wr;
  logic [TAP_W-1:0] tap_nxt;
  logic [MOD_W-1:0] mod_nxt;
  logic apply_edge;
  logic step_up;
  logic step_down;
  logic [31:0] wmask;
  logic [31:0] ctrl_word;

  assign level = ctrl_r[fllot_pkg::CTRL_LEVEL_LSB +: fllot_pkg::CTRL_LEVEL_W];
  assign gen_off = ctrl_r[fllot_pkg::CTRL_GEN_OFF];
  assign osc_used = ctrl_r[fllot_pkg::CTRL_OSC_AUX] | ctrl_r[fllot_pkg::CTRL_OSC_SUB];
  assign in_handler = ctrl_r[fllot_pkg::CTRL_IN_HANDLER];
  assign timer_on = ctrl_r[fllot_pkg::CTRL_TIMER_ON];
  // bypass on xt1 counts only in high-frequency mode
  assign bypass_on = (ctrl_r[fllot_pkg::CTRL_BYPASS1] & ctrl_r[fllot_pkg::CTRL_XT1_HF])
                     | ctrl_r[fllot_pkg::CTRL_BYPASS2];

  // loop enable decode
  always_comb begin
    loop_en = 1'b1;
    if (in_handler) begin
      // handler from level 0 or 2 re-enables
      if (level == fllot_pkg::LVL_ONE && !osc_used) begin
        loop_en = 1'b0;
      end
    end else begin
      case (level)
        fllot_pkg::LVL_ACTIVE: loop_en = 1'b1;
        fllot_pkg::LVL_ZERO: loop_en = osc_used | timer_on;
        fllot_pkg::LVL_ONE: loop_en = osc_used;
        default: loop_en = !gen_off;
      endcase
    end
  end

  assign frequency_lock_loop_on = loop_en_r;
  // oscillator stays alive whenever the loop or a derived clock needs it
  assign tunable_oscillator_on = loop_en_r | osc_used | (level == fllot_pkg::LVL_ZERO && timer_on);

  // pin inputs are synchronous: one history stage for edge detection
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ref_hist_r <= 2'h0;
      osc_hist_r <= 2'h0;
      loop_en_r <= 1'b0;
    end else if (clk_en) begin
      ref_hist_r <= {ref_hist_r[0], ref_clk_in};
      osc_hist_r <= {osc_hist_r[0], osc_clk_in};
      loop_en_r <= loop_en;
    end
  end

  assign ref_rise = ref_hist_r[0] & ~ref_hist_r[1];
  assign osc_rise = osc_hist_r[0] & ~osc_hist_r[1];

  // loop sequencer: arm on first edge, count to second edge, apply on third
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fllot_pkg::FLLOT_IDLE: if (loop_en_r) state_nxt = fllot_pkg::FLLOT_ARM;
      fllot_pkg::FLLOT_ARM: if (ref_rise) state_nxt = fllot_pkg::FLLOT_COUNT;
      fllot_pkg::FLLOT_COUNT: if (ref_rise) state_nxt = fllot_pkg::FLLOT_APPLY;
      fllot_pkg::FLLOT_APPLY: if (ref_rise) state_nxt = fllot_pkg::FLLOT_ARM;
      default: state_nxt = fllot_pkg::FLLOT_IDLE;
    endcase
    // dropping enable abandons the iteration so no partial count is applied
    if (!loop_en_r) state_nxt = fllot_pkg::FLLOT_IDLE;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= fllot_pkg::FLLOT_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // oscillator cycle counter inside the reference window
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_cnt_r <= '0;
      last_cnt_r <= '0;
    end else if (clk_en) begin
      if (state_r == fllot_pkg::FLLOT_ARM) begin
        osc_cnt_r <= '0;
      end else if (state_r == fllot_pkg::FLLOT_COUNT) begin
        if (ref_rise) begin
          last_cnt_r <= osc_cnt_r;
        end else if (osc_rise && !(&osc_cnt_r)) begin
          osc_cnt_r <= osc_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // adjust only at the end of the apply period
  // a dropped enable must not let a pending apply land
  assign apply_edge = loop_en_r && (state_r == fllot_pkg::FLLOT_APPLY) && ref_rise;
  assign step_up = apply_edge && (last_cnt_r < target_r);
  assign step_down = apply_edge && (last_cnt_r > target_r);

  fllot_step #(
    .TAP_W(TAP_W),
    .MOD_W(MOD_W)
  ) u_step (
    .tap(tap_r),
    .modv(mod_r),
    .up(step_up),
    .down(step_down),
    .tap_nxt(tap_nxt),
    .mod_nxt(mod_nxt)
  );

  // bus side
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
  end
  assign wr_hit = avs_write && clk_en;
  assign sw_setting_wr = wr_hit && avs_address == fllot_pkg::OFS_SETTING;
  assign ctrl_word = {{(32-fllot_pkg::CTRL_W){1'b0}}, ctrl_r};

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= fllot_pkg::CTRL_RST;
      target_r <= fllot_pkg::TARGET_RST;
    end else if (wr_hit) begin
      // a zero written to the bypass bit ends bypass mode
      if (avs_address == fllot_pkg::OFS_CTRL) begin
        ctrl_r <= fllot_pkg::CTRL_W'((ctrl_word & ~wmask) | (avs_writedata & wmask));
      end
      if (avs_address == fllot_pkg::OFS_TARGET) begin
        target_r <= CNT_W'(({{(32-CNT_W){1'b0}}, target_r} & ~wmask) | (avs_writedata & wmask));
      end
    end
  end

  // tap and modulation register: software preload, else loop step
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tap_r <= fllot_pkg::SETTING_RST[SW-1:MOD_W];
      mod_r <= fllot_pkg::SETTING_RST[MOD_W-1:0];
    end else if (clk_en) begin
      if (sw_setting_wr) begin
        tap_r <= avs_writedata[SW-1:MOD_W];
        mod_r <= avs_writedata[MOD_W-1:0];
      end else begin
        tap_r <= tap_nxt;
        mod_r <= mod_nxt;
      end
    end
  end

  // first-order modulator: mod of every 2^MOD_W clock cycles pick tap+1
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dith_acc_r <= '0;
      dith_r <= 1'b0;
    end else if (clk_en) begin
      {dith_r, dith_acc_r} <= {1'b0, dith_acc_r} + {1'b0, mod_r};
    end
  end

  assign tap_select_field = tap_r;
  assign modulation_field = mod_r;
  assign tap_dither_sel = dith_r;

  // low-current decision is taken in sleep level four only
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      low_cur_r <= 1'b0;
    end else if (clk_en) begin
      low_cur_r <= (level == fllot_pkg::LVL_FOUR) && !in_handler && !bypass_on;
    end
  end
  assign power_manager_low_current = low_cur_r;

  // reads answer one cycle after the request; writes wait only while clk_en is low
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      rd_ack_r <= avs_read && !rd_ack_r;
      if (avs_read && !rd_ack_r) begin
        case (avs_address)
          fllot_pkg::OFS_CTRL: rdata_r <= ctrl_word;
          fllot_pkg::OFS_TARGET: rdata_r <= {{(32-CNT_W){1'b0}}, target_r};
          fllot_pkg::OFS_SETTING: rdata_r <= {{(32-SW){1'b0}}, tap_r, mod_r};
          fllot_pkg::OFS_STATUS: rdata_r <= {24'h00_0000, state_r, 1'b0, tunable_oscillator_on,
                                             low_cur_r, loop_en_r};
          fllot_pkg::OFS_LASTCNT: rdata_r <= {{(32-CNT_W){1'b0}}, last_cnt_r};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign avs_readdata = rdata_r;
  // a frozen block stalls every request, even one whose answer is pending
  assign avs_waitrequest = !clk_en || (avs_read && !rd_ack_r);
endmodule

//--- verif/fllot_top_sva.sv
// port checker for the oscillator tracking loop
`timescale 1ns/1ps
module fllot_top_sva #(
  parameter int TAP_W = fllot_pkg::TAP_W,
  parameter int MOD_W = fllot_pkg::MOD_W,
  parameter int CNT_W = fllot_pkg::CNT_W
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic ref_clk_in,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [TAP_W-1:0] tap_select_field,
  input wire logic [MOD_W-1:0] modulation_field,
  input wire logic tap_dither_sel,
  input wire logic frequency_lock_loop_on
);
  logic [TAP_W+MOD_W-1:0] set_v;
  logic [3:0] rises_r;
  logic ref_d_r;
  assign set_v = {tap_select_field, modulation_field};
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // raw reference rises while the loop is on; three reference rises must be seen before any step
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ref_d_r <= 1'b0;
      rises_r <= 4'h0;
    end else begin
      ref_d_r <= ref_clk_in;
      if (!frequency_lock_loop_on) begin
        rises_r <= 4'h0;
      end else if (ref_clk_in && !ref_d_r && rises_r != 4'hf) begin
        rises_r <= rises_r + 4'h1;
      end
    end
  end
  a_step_one_lsb: assert property (
    !$past(avs_write) |-> set_v == $past(set_v) || set_v == $past(set_v) + 1'b1 || set_v == $past(set_v) - 1'b1)
    else $error("setting jumped");
  a_off_holds_set: assert property (
    !$past(frequency_lock_loop_on) && !$past(frequency_lock_loop_on, 2) && !$past(avs_write) |-> $stable(set_v))
    else $error("setting moved while loop off");
  a_full_window: assert property (
    set_v != $past(set_v) && !$past(avs_write) |-> rises_r >= 4'h3) else $error("step before full window");
  a_no_dither_zero: assert property (
    modulation_field == '0 && $past(modulation_field) == '0 |-> !tap_dither_sel) else $error("dither at zero");
  a_write_no_wait: assert property (avs_write && clk_en |-> !avs_waitrequest) else $error("write waited");
  a_read_one_wait: assert property ($rose(avs_read) && clk_en |-> avs_waitrequest ##1 (!avs_waitrequest || !clk_en))
    else $error("read answer late");
  a_stall_when_off: assert property (!clk_en && (avs_read || avs_write) |-> avs_waitrequest) else $error("no stall");
  a_freeze_on_hold: assert property (!$past(clk_en) |-> $stable(set_v) && $stable(frequency_lock_loop_on))
    else $error("moved while frozen");
  a_readdata_hold: assert property (!$past(avs_read) |-> $stable(avs_readdata)) else $error("read data moved");
endmodule

//--- verif/fllot_top_tb.sv
// self-checking bench for the oscillator tracking loop
`timescale 1ns/1ps
module fllot_top_tb;
  localparam int TW = fllot_pkg::TAP_W;
  localparam int MW = fllot_pkg::MOD_W;
  localparam logic [10:0] CV [16] = '{11'h000, 11'h010, 11'h400, 11'h00a, 11'h00b, 11'h00c, 11'h04a, 11'h040,
    11'h041, 11'h007, 11'h004, 11'h184, 11'h084, 11'h204, 11'h104, 11'h044};
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic ref_clk_in = 1'b0, osc_clk_in = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, tap_dither_sel, frequency_lock_loop_on, tunable_oscillator_on, power_manager_low_current;
  logic [TW-1:0] tap_select_field;
  logic [MW-1:0] modulation_field;
  logic [TW+MW-1:0] set_v;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int phase = 0;
  int nd = 0;
  assign set_v = {tap_select_field, modulation_field};
  always #5 clock = ~clock;
  fllot_top DUT (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .ref_clk_in(ref_clk_in), .osc_clk_in(osc_clk_in),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tap_select_field(tap_select_field), .modulation_field(modulation_field), .tap_dither_sel(tap_dither_sel),
    .frequency_lock_loop_on(frequency_lock_loop_on), .tunable_oscillator_on(tunable_oscillator_on),
    .power_manager_low_current(power_manager_low_current));
  // reference every 24 cycles, oscillator every 6, offset so no rising edges share a cycle: 4 counts a window
  always @(posedge clock) begin
    phase <= (phase + 1) % 24;
    ref_clk_in <= phase < 12;
    osc_clk_in <= (phase + 3) % 6 < 3;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until the rising edge that sees waitrequest low; read data taken at that edge
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= ~we;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic track(input logic [31:0] exp);
    logic [TW+MW-1:0] s;
    int n;
    s = set_v;
    n = 0;
    xfer(1'b1, fllot_pkg::OFS_CTRL, 32'h7);
    while (set_v === s && n < 200) begin
      @(negedge clock);
      n++;
    end
    check(set_v, exp);
    check(n >= 48 && n <= 80, 1'b1);
    xfer(1'b1, fllot_pkg::OFS_CTRL, 32'h0);
  endtask
  task automatic summarize();
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    check(set_v, 32'h200);
    check({frequency_lock_loop_on, power_manager_low_current, tunable_oscillator_on}, 32'h0);
    xfer(1'b0, fllot_pkg::OFS_TARGET, 32'h0);
    check(rd, 32'h20);
    xfer(1'b0, 8'h14, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, fllot_pkg::OFS_CTRL, {21'h0, CV[i]});
      repeat (3) @(posedge clock);
      @(negedge clock);
      check(frequency_lock_loop_on, 16'hfec6 >> i & 16'h1);
      check(power_manager_low_current, 16'h5420 >> i & 16'h1);
      check(tunable_oscillator_on, 16'hfec6 >> i & 16'h1);
    end
    xfer(1'b1, fllot_pkg::OFS_CTRL, 32'h0);
    xfer(1'b1, fllot_pkg::OFS_SETTING, 32'h7f);
    // enable shorter than three reference periods
    xfer(1'b1, fllot_pkg::OFS_CTRL, 32'h7);
    repeat (30) @(posedge clock);
    xfer(1'b1, fllot_pkg::OFS_CTRL, 32'h0);
    // modulation of all ones picks the upper tap in 31 of every 32 cycles
    repeat (32) begin
      @(posedge clock);
      nd += tap_dither_sel;
    end
    check(nd, 31);
    check(set_v, 32'h7f);
    track(32'h80);
    clk_en <= 1'b0;
    fork
      xfer(1'b0, fllot_pkg::OFS_LASTCNT, 32'h0);
      begin
        repeat (6) @(posedge clock);
        clk_en <= 1'b1;
      end
    join
    check(rd, 32'h4);
    xfer(1'b1, fllot_pkg::OFS_TARGET, 32'h0);
    track(32'h7f);
    xfer(1'b0, fllot_pkg::OFS_SETTING, 32'h0);
    check(rd, 32'h7f);
    summarize();
  end
endmodule
bind fllot_top fllot_top_sva #(.TAP_W(TAP_W), .MOD_W(MOD_W), .CNT_W(CNT_W)) u_sva (.clock(clock), .arst_n(arst_n),
  .clk_en(clk_en), .ref_clk_in(ref_clk_in), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .tap_select_field(tap_select_field), .modulation_field(modulation_field),
  .tap_dither_sel(tap_dither_sel), .frequency_lock_loop_on(frequency_lock_loop_on));
